// ==== block_move_unit.sv ====
// block move unit: programmed i/o commands, address control, memory port
//
// Behaviour
// R1: unit answers at an even device address and the next odd one.
// R2: control function 0 at even address starts a block transfer.
// R3: control function 0 at odd address initializes the unit.
// R4: control function 1 at even address resets the unit.
// R5: control function 1 at odd address arms test data transfer.
// R6: armed output transfer loads write buffer, then disarms test state.
// R7: armed input transfer returns read buffer, then disarms test state.
// R8: control function 2 at even address runs one test memory write.
// R9: control function 2 at odd address runs one test memory read.
// R10: output transfer to even address loads initial-address register.
// R11: output transfer to odd address loads final-address register.
// R12: input transfer from even address returns initial-address register.
// R13: input transfer from odd address returns final-address register.
// R14: sense function 0 at even address is true when not busy.
// R15: sense function 0 at odd address is true after abnormal stop.
// R16: sense function 1 at even address is true at end of block.
// R17: host selects unit and checks sense before moving data words.
// R18: one word buffered each way between memory port and peripheral.
// R19: odd parity generated on words written into memory.
// R20: instruction carries device address bits 0-5, function bits 6-8.
// R21: sense response line asserted when the sensed condition holds.
// R22: transfer advances address from initial, busy until final, then end.
// R23: reset clears busy, abnormal stop, end of block and test arm.
//
// Added by the designer: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

`include "block_move_regs.svh"

module block_move_unit (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [5:0] io_dev_addr,
	input wire logic [2:0] io_func,
	input wire logic external_control_op,
	input wire logic sense_op,
	input wire logic output_xfer,
	input wire logic input_xfer,
	input wire logic [15:0] io_data_in,
	output logic [15:0] io_data_out,
	output logic io_data_oe,
	output logic sense_response_line,
	input wire logic parity_enable,
	input wire logic dir_to_memory,
	input wire logic per_word_valid,
	input wire logic [15:0] per_word_in,
	output logic per_word_taken,
	output logic per_word_avail,
	output logic [15:0] per_word_out,
	input wire logic per_word_accept,
	input wire logic per_abnormal_stop,
	output logic mem_req,
	output logic mem_we,
	output logic [15:0] mem_addr,
	output logic [15:0] mem_wdata,
	output logic mem_wparity,
	input wire logic mem_ack,
	input wire logic [15:0] mem_rdata,
	output logic busy
);

	block_move_pkg::move_state_t state_ff;
	block_move_pkg::word_t init_addr_ff, final_addr_ff, wbuf_ff, rbuf_ff;
	block_move_pkg::word_t io_data_out_ff, per_word_out_ff;
	block_move_pkg::word_t mem_addr_ff, mem_wdata_ff;
	logic busy_ff, abnormal_ff, end_block_ff, test_arm_ff, test_cyc_ff;
	logic to_mem_ff, io_data_oe_ff, sense_resp_ff, per_taken_ff;
	logic per_avail_ff, mem_req_ff, mem_we_ff, mem_wpar_ff, wpar;

	// command decode
	logic mine, odd, clear_cmd, last_word, mem_done, stop_now, word_done;
	logic cmd_activate, cmd_init, cmd_reset;
	logic cmd_test_arm, cmd_test_wr, cmd_test_rd;
	logic out_even, out_odd, in_even, in_odd;

	function automatic logic addr_hit(input logic [5:0] a);
		addr_hit = (a[5:1] == 5'(`BMU_DEV_BASE >> 1)); // R1
	endfunction

	function automatic logic ctl_is(input logic op, input logic [2:0] fn,
		input logic [2:0] want);
		ctl_is = op && (fn == want); // R20
	endfunction

	assign mine = addr_hit(io_dev_addr); // R1 R20
	assign odd = io_dev_addr[0]; // R1
	assign cmd_activate = mine && !odd &&
		ctl_is(external_control_op, io_func, `BMU_FN_0); // R2
	assign cmd_init = mine && odd &&
		ctl_is(external_control_op, io_func, `BMU_FN_0); // R3
	assign cmd_reset = mine && !odd &&
		ctl_is(external_control_op, io_func, `BMU_FN_1); // R4
	assign cmd_test_arm = mine && odd &&
		ctl_is(external_control_op, io_func, `BMU_FN_1); // R5
	assign cmd_test_wr = mine && !odd &&
		ctl_is(external_control_op, io_func, `BMU_FN_2); // R8
	assign cmd_test_rd = mine && odd &&
		ctl_is(external_control_op, io_func, `BMU_FN_2); // R9
	assign out_even = mine && !odd && output_xfer;
	assign out_odd = mine && odd && output_xfer;
	assign in_even = mine && !odd && input_xfer;
	assign in_odd = mine && odd && input_xfer;
	// initialize does everything reset does and also clears the registers
	assign clear_cmd = cmd_reset || cmd_init; // R23
	assign last_word = (init_addr_ff == final_addr_ff);
	assign mem_done = (state_ff == block_move_pkg::ST_MEM) && mem_ack;
	assign stop_now = per_abnormal_stop && busy_ff;
	assign word_done = (mem_done && to_mem_ff) ||
		(state_ff == block_move_pkg::ST_DRAIN &&
		per_word_accept && per_avail_ff);

	odd_parity_gen u_parity (
		.word(wbuf_ff),
		.enable(parity_enable),
		.parity(wpar)
	);

	// transfer sequencer
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_ff <= block_move_pkg::ST_IDLE;
		end else if (clear_cmd || stop_now) begin
			state_ff <= block_move_pkg::ST_IDLE; // R23
		end else begin
			unique case (state_ff)
				block_move_pkg::ST_IDLE: begin
					if (cmd_activate) begin
						state_ff <= dir_to_memory ? block_move_pkg::ST_FILL :
							block_move_pkg::ST_MEM; // R2
					end else if (cmd_test_wr || cmd_test_rd) begin
						state_ff <= block_move_pkg::ST_MEM; // R8 R9
					end
				end
				block_move_pkg::ST_FILL: begin
					if (per_word_valid) begin
						state_ff <= block_move_pkg::ST_MEM; // R18
					end
				end
				block_move_pkg::ST_MEM: begin
					if (mem_ack) begin
						if (test_cyc_ff) begin
							state_ff <= block_move_pkg::ST_IDLE;
						end else if (!to_mem_ff) begin
							state_ff <= block_move_pkg::ST_DRAIN; // R18
						end else begin
							state_ff <= last_word ? block_move_pkg::ST_IDLE :
								block_move_pkg::ST_FILL; // R22
						end
					end
				end
				block_move_pkg::ST_DRAIN: begin
					if (per_word_accept && per_avail_ff) begin
						state_ff <= last_word ? block_move_pkg::ST_IDLE :
							block_move_pkg::ST_MEM; // R22
					end
				end
			endcase
		end
	end

	// direction and test-cycle qualifiers, latched at launch
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			to_mem_ff <= 1'b0;
			test_cyc_ff <= 1'b0;
		end else if (state_ff == block_move_pkg::ST_IDLE) begin
			if (cmd_activate) begin
				to_mem_ff <= dir_to_memory;
				test_cyc_ff <= 1'b0;
			end else if (cmd_test_wr || cmd_test_rd) begin
				to_mem_ff <= cmd_test_wr; // R8 R9
				test_cyc_ff <= 1'b1;
			end
		end
	end

	// busy covers block transfers only; test cycles are not sensed as busy
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			busy_ff <= 1'b0;
		end else if (clear_cmd || stop_now) begin
			busy_ff <= 1'b0; // R23
		end else if (cmd_activate && state_ff == block_move_pkg::ST_IDLE) begin
			busy_ff <= 1'b1; // R2
		end else if (busy_ff && last_word && word_done) begin
			busy_ff <= 1'b0; // R22
		end
	end

	// end of block: set wins over a clearing command in the same cycle
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			end_block_ff <= 1'b0;
		end else if (busy_ff && !stop_now && last_word && word_done) begin
			end_block_ff <= 1'b1; // R22
		end else if (clear_cmd || cmd_activate) begin
			end_block_ff <= 1'b0; // R23
		end
	end

	// abnormal stop flag, set wins over clear
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			abnormal_ff <= 1'b0;
		end else if (stop_now) begin
			abnormal_ff <= 1'b1; // R15
		end else if (clear_cmd || cmd_activate) begin
			abnormal_ff <= 1'b0; // R23
		end
	end

	// test data transfer arm, dropped by the next data transfer
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			test_arm_ff <= 1'b0;
		end else if (cmd_test_arm) begin
			test_arm_ff <= 1'b1; // R5
		end else if (clear_cmd) begin
			test_arm_ff <= 1'b0; // R23
		end else if (mine && (output_xfer || input_xfer)) begin
			test_arm_ff <= 1'b0; // R6 R7
		end
	end

	// initial-address register doubles as the running transfer address
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			init_addr_ff <= `BMU_WORD_RST;
		end else if (cmd_init) begin
			init_addr_ff <= `BMU_WORD_RST;
		end else if (out_even && !test_arm_ff) begin
			init_addr_ff <= io_data_in; // R10
		end else if (busy_ff && !last_word && !stop_now && word_done) begin
			init_addr_ff <= 16'(init_addr_ff + `BMU_ADDR_STEP); // R22
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			final_addr_ff <= `BMU_WORD_RST;
		end else if (cmd_init) begin
			final_addr_ff <= `BMU_WORD_RST;
		end else if (out_odd && !test_arm_ff) begin
			final_addr_ff <= io_data_in; // R11
		end
	end

	// write buffer: from the peripheral, or from the i/o bus under test
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			wbuf_ff <= `BMU_WORD_RST;
		end else if (cmd_init) begin
			wbuf_ff <= `BMU_WORD_RST;
		end else if (mine && output_xfer && test_arm_ff) begin
			wbuf_ff <= io_data_in; // R6
		end else if (state_ff == block_move_pkg::ST_FILL && per_word_valid &&
			!clear_cmd && !stop_now) begin
			wbuf_ff <= per_word_in; // R18
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			per_taken_ff <= 1'b0;
		end else begin
			per_taken_ff <= state_ff == block_move_pkg::ST_FILL &&
				per_word_valid && !clear_cmd && !stop_now; // R18
		end
	end

	// read buffer: filled by every completed memory read
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rbuf_ff <= `BMU_WORD_RST;
		end else if (cmd_init) begin
			rbuf_ff <= `BMU_WORD_RST;
		end else if (mem_done && !mem_we_ff) begin
			rbuf_ff <= mem_rdata; // R9 R18
		end
	end

	// word offered to the peripheral until it accepts
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			per_avail_ff <= 1'b0;
			per_word_out_ff <= `BMU_WORD_RST;
		end else if (clear_cmd || stop_now) begin
			per_avail_ff <= 1'b0;
		end else if (mem_done && !mem_we_ff && !test_cyc_ff) begin
			per_avail_ff <= 1'b1; // R18
			per_word_out_ff <= mem_rdata;
		end else if (per_word_accept) begin
			per_avail_ff <= 1'b0;
		end
	end

	// memory port request, held until acknowledged
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			mem_req_ff <= 1'b0;
			mem_we_ff <= 1'b0;
			mem_addr_ff <= `BMU_WORD_RST;
			mem_wdata_ff <= `BMU_WORD_RST;
			mem_wpar_ff <= 1'b0;
		end else if (clear_cmd || stop_now) begin
			mem_req_ff <= 1'b0;
		end else if (state_ff == block_move_pkg::ST_MEM && !mem_req_ff) begin
			mem_req_ff <= 1'b1; // R8 R9
			mem_we_ff <= to_mem_ff;
			mem_addr_ff <= init_addr_ff; // R22
			mem_wdata_ff <= wbuf_ff;
			mem_wpar_ff <= wpar; // R19
		end else if (mem_ack) begin
			mem_req_ff <= 1'b0;
		end
	end

	// input transfer answer, one cycle after the request
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			io_data_oe_ff <= 1'b0;
			io_data_out_ff <= `BMU_WORD_RST;
		end else begin
			io_data_oe_ff <= in_even || in_odd;
			if (mine && input_xfer && test_arm_ff) begin
				io_data_out_ff <= rbuf_ff; // R7
			end else if (in_even) begin
				io_data_out_ff <= init_addr_ff; // R12
			end else if (in_odd) begin
				io_data_out_ff <= final_addr_ff; // R13
			end else begin
				io_data_out_ff <= `BMU_WORD_RST;
			end
		end
	end

	// sense answer, one cycle after the request
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			sense_resp_ff <= 1'b0;
		end else begin
			sense_resp_ff <= mine && sense_op && ( // R21
				(!odd && io_func == `BMU_FN_0 && !busy_ff) || // R14
				(odd && io_func == `BMU_FN_0 && abnormal_ff) || // R15
				(!odd && io_func == `BMU_FN_1 && end_block_ff)); // R16
		end
	end

	assign io_data_out = io_data_out_ff;
	assign io_data_oe = io_data_oe_ff;
	assign sense_response_line = sense_resp_ff;
	assign per_word_taken = per_taken_ff;
	assign per_word_avail = per_avail_ff;
	assign per_word_out = per_word_out_ff;
	assign mem_req = mem_req_ff;
	assign mem_we = mem_we_ff;
	assign mem_addr = mem_addr_ff;
	assign mem_wdata = mem_wdata_ff;
	assign mem_wparity = mem_wpar_ff;
	assign busy = busy_ff;

endmodule

`default_nettype wire

// ==== block_move_regs.svh ====
// constants of the block move unit: command codes, widths, reset values
`ifndef BLOCK_MOVE_REGS_SVH
`define BLOCK_MOVE_REGS_SVH

`define BMU_WORD_W 16
`define BMU_DEV_W 6
`define BMU_FN_W 3
`define BMU_DEV_BASE 6'h02
`define BMU_FN_0 3'h0
`define BMU_FN_1 3'h1
`define BMU_FN_2 3'h2
`define BMU_WORD_RST 16'h0000
`define BMU_ADDR_STEP 16'h0001

`endif

// ==== block_move_pkg.sv ====
// types shared by the block move unit
package block_move_pkg;

	typedef logic [15:0] word_t;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_FILL,
		ST_MEM,
		ST_DRAIN
	} move_state_t;

endpackage

// ==== odd_parity_gen.sv ====
// odd parity over one memory word
`timescale 1ns/1ps
`default_nettype none

module odd_parity_gen (
	input wire logic [15:0] word,
	input wire logic enable,
	output logic parity
);

	// bit makes the count of ones odd; forced low when parity is unused
	assign parity = enable & ~(^word);

endmodule

`default_nettype wire

// ==== bmu_chk.sv ====
// assertions on the block move unit ports
`timescale 1ns/1ps
`default_nettype none
module bmu_chk (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [5:0] io_dev_addr,
	input wire logic [2:0] io_func,
	input wire logic external_control_op,
	input wire logic sense_op,
	input wire logic input_xfer,
	input wire logic [15:0] io_data_out,
	input wire logic io_data_oe,
	input wire logic sense_response_line,
	input wire logic parity_enable,
	input wire logic per_word_taken,
	input wire logic per_abnormal_stop,
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic [15:0] mem_addr,
	input wire logic [15:0] mem_wdata,
	input wire logic mem_wparity,
	input wire logic mem_ack,
	input wire logic busy
);
	logic ours;
	assign ours = io_dev_addr[5:1] == 5'h01;
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	a_read_answer: assert property (input_xfer && ours |=> io_data_oe)
		else $error("no answer to input transfer");
	a_oe_cause: assert property (io_data_oe |->
		$past(input_xfer) && $past(ours))
		else $error("bus driven without input transfer");
	a_idle_data: assert property (!io_data_oe |->
		io_data_out == 16'h0000)
		else $error("data out not zero while idle");
	a_sense_cause: assert property (sense_response_line |->
		$past(sense_op) && $past(ours))
		else $error("sense response without sense");
	a_busy_sense: assert property (sense_op && io_dev_addr == 6'h02 &&
		io_func == 3'h0 |=> sense_response_line == !$past(busy))
		else $error("not busy sense wrong");
	a_busy_start: assert property ($rose(busy) |->
		$past(external_control_op) && $past(io_dev_addr) == 6'h02
		&& $past(io_func) == 3'h0)
		else $error("busy without activate");
	a_req_hold: assert property (mem_req && !mem_ack &&
		!external_control_op && !per_abnormal_stop |=>
		mem_req && $stable(mem_addr) && $stable(mem_we))
		else $error("memory request dropped early");
	a_odd_parity: assert property (mem_req && mem_we && parity_enable
		|-> ^{mem_wdata, mem_wparity})
		else $error("write parity not odd");
	// request is raised the cycle after the taken pulse
	a_taken_write: assert property (per_word_taken |=> mem_req && mem_we)
		else $error("word taken without memory write");
	a_abort_stop: assert property (per_abnormal_stop && busy |=> !busy)
		else $error("stop did not end transfer");
	cover property (per_word_taken);
	cover property (mem_req && !mem_we && mem_ack);
	cover property ($fell(busy) && !per_abnormal_stop);
endmodule
bind block_move_unit bmu_chk bmu_chk_i (.clk, .arst_n, .io_dev_addr, .io_func,
	.external_control_op, .sense_op, .input_xfer, .io_data_out, .io_data_oe,
	.sense_response_line, .parity_enable, .per_word_taken, .per_abnormal_stop,
	.mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_wparity, .mem_ack, .busy);
`default_nettype wire

// ==== bmu_far_model.sv ====
// memory behind the fast port and a simple peripheral
`timescale 1ns/1ps
`default_nettype none
module bmu_far_model (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [3:0] lat,
	input wire logic per_en,
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic [15:0] mem_addr,
	input wire logic [15:0] mem_wdata,
	output logic mem_ack,
	output logic [15:0] mem_rdata,
	output logic per_word_valid,
	output logic [15:0] per_word_in,
	input wire logic per_word_taken,
	input wire logic per_word_avail,
	input wire logic [15:0] per_word_out,
	output logic per_word_accept
);
	logic [15:0] mem [0:63];
	logic [15:0] rx [0:7];
	logic [2:0] rx_n;
	logic [3:0] cnt;
	logic [15:0] w;
	// lat sets slow or prompt answers
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt <= 4'h0;
			mem_ack <= 1'b0;
			mem_rdata <= 16'h0000;
		end else begin
			mem_ack <= mem_req && !mem_ack && cnt >= lat;
			cnt <= (mem_req && !mem_ack) ? cnt + 4'h1 : 4'h0;
			// outside an answer the data inverts every cycle
			mem_rdata <= ~mem_rdata;
			if (mem_req && !mem_ack && cnt >= lat) begin
				mem_rdata <= mem[mem_addr[5:0]];
				if (mem_we)
					mem[mem_addr[5:0]] <= mem_wdata;
			end
		end
	end
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			w <= 16'h0100;
			per_word_valid <= 1'b0;
			per_word_in <= 16'h0000;
			per_word_accept <= 1'b0;
			rx_n <= 3'h0;
		end else begin
			per_word_valid <= per_en;
			per_word_in <= per_en ? w : ~per_word_in;
			if (per_word_taken)
				w <= w + 16'h0001;
			per_word_accept <= per_word_avail && !per_word_accept;
			if (per_word_avail && per_word_accept) begin
				rx[rx_n] <= per_word_out;
				rx_n <= rx_n + 3'h1;
			end
		end
	end
endmodule
`default_nettype wire

// ==== tb_top.sv ====
// self-checking bench of the block move unit
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic clk = 0, arst_n = 0, external_control_op = 0, sense_op = 0;
	logic output_xfer = 0, input_xfer = 0, parity_enable = 1;
	logic dir_to_memory = 0, per_abnormal_stop = 0, per_en = 0;
	logic [5:0] io_dev_addr = 6'h00;
	logic [2:0] io_func = 3'h0;
	logic [3:0] lat = 4'h0;
	logic [15:0] io_data_in = 16'h0000, io_data_out, per_word_in, per_word_out;
	logic [15:0] mem_addr, mem_wdata, mem_rdata;
	logic io_data_oe, sense_response_line, per_word_valid, per_word_taken;
	logic per_word_avail, per_word_accept, mem_req, mem_we, mem_wparity;
	logic mem_ack, busy;
	int bad_count = 0, total_checks = 0, i;
	always #2.5 clk = ~clk;
	block_move_unit block_move_unit_i (.clk, .arst_n, .io_dev_addr, .io_func,
		.external_control_op, .sense_op, .output_xfer, .input_xfer, .io_data_in,
		.io_data_out, .io_data_oe, .sense_response_line, .parity_enable,
		.dir_to_memory, .per_word_valid, .per_word_in, .per_word_taken,
		.per_word_avail, .per_word_out, .per_word_accept, .per_abnormal_stop,
		.mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_wparity, .mem_ack,
		.mem_rdata, .busy);
	bmu_far_model bmu_far_model_i (.clk, .arst_n, .lat, .per_en, .mem_req,
		.mem_we, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata, .per_word_valid,
		.per_word_in, .per_word_taken, .per_word_avail, .per_word_out,
		.per_word_accept);
	task automatic chk_w(input logic [15:0] g, input logic [15:0] e);
		total_checks++;
		if (g !== e) begin
			bad_count++;
			$display("Error at %0t: word %h expected %h", $time, g, e);
		end
	endtask
	task automatic chk_b(input logic g, input logic e);
		total_checks++;
		if (g !== e) begin
			bad_count++;
			$display("Error at %0t: flag %b expected %b", $time, g, e);
		end
	endtask
	// k: 0 control, 1 sense, 2 output, 3 input
	task automatic cmd(input int k, input logic [5:0] a, input logic [2:0] f,
		input logic [15:0] d);
		@(posedge clk);
		external_control_op <= k == 0;
		sense_op <= k == 1;
		output_xfer <= k == 2;
		input_xfer <= k == 3;
		io_dev_addr <= a;
		io_func <= f;
		io_data_in <= d;
		@(posedge clk);
		{external_control_op, sense_op, output_xfer, input_xfer} <= 4'h0;
		#1;
	endtask
	task automatic sense(input logic [5:0] a, input logic [2:0] f, input logic e);
		cmd(1, a, f, 16'h0000);
		chk_b(sense_response_line, e);
	endtask
	task automatic rd(input logic [5:0] a, input logic [15:0] e);
		cmd(3, a, 3'h0, 16'h0000);
		chk_b(io_data_oe, 1'b1);
		chk_w(io_data_out, e);
	endtask
	task automatic wait_idle;
		// test cycles raise the request only one edge after the command is sampled
		@(posedge clk);
		#1;
		for (i = 0; i < 300 && (busy !== 1'b0 || mem_req !== 1'b0); i++) begin
			@(posedge clk);
			#1;
		end
		chk_b(busy, 1'b0);
		chk_b(mem_req, 1'b0);
	endtask
	task automatic t_regs;
		cmd(2, 6'h02, 3'h0, 16'h0010);
		cmd(2, 6'h03, 3'h0, 16'h0012);
		rd(6'h02, 16'h0010);
		rd(6'h03, 16'h0012);
		cmd(3, 6'h04, 3'h0, 16'h0000);
		chk_b(io_data_oe, 1'b0);
		sense(6'h02, 3'h0, 1'b1);
		sense(6'h03, 3'h0, 1'b0);
		sense(6'h02, 3'h1, 1'b0);
		$display("regs test done");
	endtask
	task automatic t_test;
		cmd(0, 6'h03, 3'h1, 16'h0000);
		cmd(2, 6'h02, 3'h0, 16'hA5A4);
		rd(6'h02, 16'h0010);
		cmd(0, 6'h02, 3'h2, 16'h0000);
		wait_idle();
		chk_w(bmu_far_model_i.mem[16], 16'hA5A4);
		cmd(0, 6'h03, 3'h2, 16'h0000);
		wait_idle();
		cmd(0, 6'h03, 3'h1, 16'h0000);
		rd(6'h03, 16'hA5A4);
		rd(6'h03, 16'h0012);
		cmd(0, 6'h03, 3'h1, 16'h0000);
		cmd(0, 6'h02, 3'h1, 16'h0000);
		cmd(2, 6'h02, 3'h0, 16'h0020);
		rd(6'h02, 16'h0020);
		$display("test path done");
	endtask
	task automatic t_blk;
		cmd(2, 6'h03, 3'h0, 16'h0022);
		@(posedge clk);
		lat <= 4'h3;
		per_en <= 1'b1;
		dir_to_memory <= 1'b1;
		cmd(0, 6'h02, 3'h0, 16'h0000);
		chk_b(busy, 1'b1);
		wait_idle();
		per_en <= 1'b0;
		for (int j = 0; j < 3; j++)
			chk_w(bmu_far_model_i.mem[32 + j], 16'h0100 + j);
		sense(6'h02, 3'h1, 1'b1);
		cmd(2, 6'h02, 3'h0, 16'h0020);
		@(posedge clk);
		dir_to_memory <= 1'b0;
		cmd(0, 6'h02, 3'h0, 16'h0000);
		wait_idle();
		for (int j = 0; j < 3; j++)
			chk_w(bmu_far_model_i.rx[j], 16'h0100 + j);
		$display("block test done");
	endtask
	task automatic t_abort;
		cmd(2, 6'h02, 3'h0, 16'h0030);
		cmd(2, 6'h03, 3'h0, 16'h003F);
		@(posedge clk);
		dir_to_memory <= 1'b1;
		cmd(0, 6'h02, 3'h0, 16'h0000);
		sense(6'h02, 3'h0, 1'b0);
		@(posedge clk);
		per_abnormal_stop <= 1'b1;
		@(posedge clk);
		per_abnormal_stop <= 1'b0;
		#1;
		chk_b(busy, 1'b0);
		sense(6'h03, 3'h0, 1'b1);
		cmd(0, 6'h02, 3'h1, 16'h0000);
		sense(6'h03, 3'h0, 1'b0);
		cmd(0, 6'h03, 3'h0, 16'h0000);
		rd(6'h02, 16'h0000);
		rd(6'h03, 16'h0000);
		$display("abort test done");
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge clk);
		arst_n <= 1'b1;
		#1;
		chk_b(busy, 1'b0);
		chk_b(io_data_oe, 1'b0);
		t_regs();
		t_test();
		t_blk();
		t_abort();
		tally_and_finish();
	end
	// whole run is about 130 cycles
	initial begin
		#20000;
		$display("Error at %0t: watchdog expired", $time);
		bad_count++;
		tally_and_finish();
	end
endmodule
`default_nettype wire
